// ### src/sllg_top.sv
// strap latch, pin role select and output gating of the clock generator
// assumes arst_n is the power-on detect and all pins are synchronous
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "sllg_consts.svh"

module sllg_top
  import sllg_pkg::*;
#(
  parameter int unsigned WIN_CYCLES = `SLLG_WIN_TIME_US * `SLLG_CLK_MHZ
)
(
  // clock and power detect
  input  wire logic        clk,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // reference, memory clock and halt
  input  wire logic        ref_clk_in,
  input  wire logic        memory_clock_in,
  input  wire logic        clock_halt_n,
  // dual-purpose strap pins
  input  wire logic [4:0]  strap_in,
  output logic [4:0]       dual_out,
  output logic [4:0]       dual_oe,
  // pin 2: reference out or bus stop in
  input  wire logic        pin2_in,
  output logic             reference_out_zero,
  output logic             pin2_oe,
  // bus clocks two to five
  output logic [3:0]       bus_clk_out,
  // processor clocks
  output logic             proc_clk_free,
  output logic             gated_processor_clock,
  // memory clocks
  output logic [11:0]      gated_memory_clocks,
  output logic             memory_clock_free
);

  sllg_top_state_type s_r;
  sllg_top_state_type s_nxt;

  sllg_gate_if mem_if();
  sllg_gate_if proc_if();

  logic rel;
  logic proc_rise;
  logic bus_rise;
  logic bus_lvl;
  logic mode_known;
  logic bus_stop;
  logic apb_setup;
  logic apb_wr;

  // ==========================================================
  // clock gates
  sllg_gate u_mem_gate
  (
    .clk    (clk),
    .arst_n (arst_n),
    .gi     (mem_if.gate)
  );

  sllg_gate u_proc_gate
  (
    .clk    (clk),
    .arst_n (arst_n),
    .gi     (proc_if.gate)
  );

  assign mem_if.src      = memory_clock_in;
  assign mem_if.tick     = proc_rise;
  assign mem_if.run_req  = clock_halt_n & ~s_r.ctrl[`SLLG_CTRL_MHALT];
  assign proc_if.src     = s_r.div[`SLLG_DIV_PROC];
  assign proc_if.tick    = proc_rise;
  assign proc_if.run_req = clock_halt_n & ~s_r.ctrl[`SLLG_CTRL_PHALT];

  // ==========================================================
  // next state
  always_comb
  begin
    s_nxt = s_r;
    // reset release synchroniser
    s_nxt.rsync = {s_r.rsync[0], 1'b1};
    rel = s_r.rsync[1];

    // divider for internal clock levels
    if (rel)
    begin
      s_nxt.div = s_r.div + `SLLG_DIV_W'(1);
    end
    proc_rise = !s_r.div[`SLLG_DIV_PROC] && s_nxt.div[`SLLG_DIV_PROC];
    bus_rise  = !s_r.div[`SLLG_DIV_BUS] && s_nxt.div[`SLLG_DIV_BUS];
    bus_lvl   = s_nxt.div[`SLLG_DIV_BUS];

    // strap window sequence
    case (s_r.phase)
      PH_RESET:
      begin
        if (rel)
        begin
          s_nxt.phase = PH_WINDOW;
        end
      end
      PH_WINDOW:
      begin
        s_nxt.win_cnt = s_r.win_cnt + `SLLG_WIN_W'(1);
        if (s_r.win_cnt == `SLLG_WIN_W'(WIN_CYCLES - 1))
        begin
          s_nxt.phase = PH_LATCH;
        end
      end
      PH_LATCH:
      begin
        // board straps set the levels while undriven
        s_nxt.strap = strap_in;
        s_nxt.phase = PH_RUN;
      end
      PH_RUN:
      begin
        // straps frozen until power is cycled
        s_nxt.strap = s_r.strap;
      end
      default:
      begin
        s_nxt.phase = PH_RESET;
      end
    endcase

    // drivers stay off until the straps are held
    s_nxt.oe = (s_nxt.phase == PH_RUN) ? 5'h1f : 5'h00;

    // pin 2 role from mode strap
    mode_known    = (s_r.phase == PH_RUN);
    s_nxt.pin2_oe = mode_known && s_r.strap[`SLLG_PIN_MODE];
    s_nxt.pin2_o  = ref_clk_in;
    bus_stop      = (mode_known && !s_r.strap[`SLLG_PIN_MODE]) ? pin2_in : 1'b1;

    // bus stop: sample on rise, apply on the next rise
    if (bus_rise)
    begin
      s_nxt.bus_samp = bus_stop;
      s_nxt.bus_run  = s_r.bus_samp;
    end
    s_nxt.bus_out = {5{bus_lvl & s_nxt.bus_run}} & ~s_r.ctrl[4:0];

    // dual pin clock outputs
    s_nxt.pout[`SLLG_PIN_MODE] = bus_lvl;
    s_nxt.pout[`SLLG_PIN_FS3]  = s_nxt.bus_out[0];
    s_nxt.pout[`SLLG_PIN_FS0]  = s_nxt.div[`SLLG_DIV_USB];
    s_nxt.pout[`SLLG_PIN_FS1]  = s_nxt.div[`SLLG_DIV_SIO];
    s_nxt.pout[`SLLG_PIN_FS2]  = ref_clk_in;

    // free copies
    s_nxt.proc_free = s_nxt.div[`SLLG_DIV_PROC];
    s_nxt.mem_free  = memory_clock_in;

    // apb slave, zero wait states
    apb_setup     = psel && !penable;
    apb_wr        = psel && penable && pwrite;
    if (apb_setup)
    begin
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata  = 32'h0;
      if (paddr == `SLLG_ADDR_CTRL)
      begin
        s_nxt.prdata = {25'h0, s_r.ctrl};
      end
      else if (paddr == `SLLG_ADDR_STAT)
      begin
        s_nxt.prdata = {23'h0, proc_if.en, mem_if.en, s_r.bus_run,
                        s_r.bus_samp, mode_known, s_r.phase, s_r.pin2_oe,
                        s_r.oe[0]};
      end
      else if (paddr == `SLLG_ADDR_STRAP)
      begin
        s_nxt.prdata = {27'h0, s_r.strap};
      end
      else
      begin
        s_nxt.pslverr = 1'b1;
      end
    end
    if (apb_wr && paddr == `SLLG_ADDR_CTRL)
    begin
      s_nxt.ctrl = pwdata[`SLLG_CTRL_W-1:0];
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '{
        rsync:     2'h0,
        phase:     PH_RESET,
        win_cnt:   '0,
        strap:     `SLLG_STRAP_RST,
        oe:        5'h00,
        pout:      5'h00,
        pin2_o:    1'b0,
        pin2_oe:   1'b0,
        div:       '0,
        bus_samp:  1'b1,
        bus_run:   1'b1,
        bus_out:   5'h00,
        proc_free: 1'b0,
        mem_free:  1'b0,
        ctrl:      `SLLG_CTRL_RST,
        prdata:    32'h0,
        pslverr:   1'b0
      };
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign prdata                = s_r.prdata;
  assign pready                = 1'b1;
  assign pslverr               = s_r.pslverr & psel & penable;
  assign dual_out              = s_r.pout;
  assign dual_oe               = s_r.oe;
  assign reference_out_zero    = s_r.pin2_o;
  assign pin2_oe               = s_r.pin2_oe;
  assign bus_clk_out           = s_r.bus_out[4:1];
  assign proc_clk_free         = s_r.proc_free;
  // first cycle after enable is a whole one
  assign gated_processor_clock = proc_if.gated;
  assign gated_memory_clocks   = {12{mem_if.gated}};
  assign memory_clock_free     = s_r.mem_free;

  // ==========================================================
  // checks
  a_window_tristate: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_r.phase != PH_RUN) |-> (dual_oe == 5'h00))
    else $error("dual pin driven before latch");

  a_latch_enable: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_r.phase == PH_LATCH) |=> (dual_oe == 5'h1f) && (s_r.strap == $past(strap_in)))
    else $error("latch did not capture and enable");

  a_strap_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_r.phase == PH_RUN) |=> $stable(s_r.strap) && (s_r.phase == PH_RUN))
    else $error("strap changed after latch");

  a_timer_reset: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_r.phase == PH_RESET) |-> (s_r.win_cnt == '0))
    else $error("window timer ran before release");

  a_window_len: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(s_r.phase == PH_LATCH) |-> ($past(s_r.win_cnt) == `SLLG_WIN_W'(WIN_CYCLES - 1)))
    else $error("window ended at wrong count");

  a_pin2_role: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_r.phase == PH_RUN) |=> (pin2_oe == $past(s_r.strap[`SLLG_PIN_MODE])))
    else $error("pin 2 role differs from mode strap");

  a_pin2_ref: assert property (
    @(posedge clk) disable iff (!arst_n)
    pin2_oe |-> (reference_out_zero == $past(ref_clk_in)))
    else $error("pin 2 does not carry reference");

  a_bus_sample: assert property (
    @(posedge clk) disable iff (!arst_n)
    (bus_rise && s_r.phase == PH_RUN && !s_r.pin2_oe && !s_r.strap[`SLLG_PIN_MODE])
      |=> (s_r.bus_samp == $past(pin2_in)))
    else $error("bus stop not sampled at bus rise");

  a_bus_held: assert property (
    @(posedge clk) disable iff (!arst_n)
    !s_r.bus_run |-> (bus_clk_out == 4'h0) && !s_r.pout[`SLLG_PIN_FS3])
    else $error("bus clock ran while stopped");

  a_mem_free: assert property (
    @(posedge clk) disable iff (!arst_n)
    $past(arst_n) |-> (memory_clock_free == $past(memory_clock_in)))
    else $error("free memory copy diverged");

  a_mem_gated: assert property (
    @(posedge clk) disable iff (!arst_n)
    !mem_if.en ##1 !mem_if.en |-> (gated_memory_clocks == 12'h000))
    else $error("memory copies ran while halted");

  a_bus_follow: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_r.bus_run && $past(s_r.ctrl[4:0]) == 5'h00)
      |-> (bus_clk_out == {4{dual_out[`SLLG_PIN_MODE]}}))
    else $error("bus clocks not following the fixed bus clock");

  a_bus_apply: assert property (
    @(posedge clk) disable iff (!arst_n)
    (bus_rise && s_r.phase == PH_RUN) |=> (s_r.bus_run == $past(s_r.bus_samp)))
    else $error("bus stop not applied at the next bus rise");

  a_bus_keep: assert property (
    @(posedge clk) disable iff (!arst_n)
    !bus_rise |=> $stable(s_r.bus_run) && $stable(s_r.bus_samp))
    else $error("bus stop moved between bus rises");

  a_stop_ignored: assert property (
    @(posedge clk) disable iff (!arst_n)
    (bus_rise && s_r.phase == PH_RUN && s_r.strap[`SLLG_PIN_MODE]) |=> s_r.bus_samp)
    else $error("bus stop sampled while pin 2 is an output");

  a_pin2_input: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_r.phase != PH_RUN || !s_r.strap[`SLLG_PIN_MODE]) |=> !pin2_oe)
    else $error("pin 2 driven while it should be an input");

  a_oe_run: assert property (
    @(posedge clk) disable iff (!arst_n)
    (s_r.phase == PH_RUN) |-> (dual_oe == 5'h1f))
    else $error("dual pin released after latch");

  a_release_hold: assert property (
    @(posedge clk) disable iff (!arst_n)
    !s_r.rsync[1] |=> $stable(s_r.div) && (s_r.phase == PH_RESET))
    else $error("divider or timer ran before release");

  a_halt_stop: assert property (
    @(posedge clk) disable iff (!arst_n)
    (!proc_if.run_req && s_r.phase == PH_RUN) [*7] |-> !proc_if.en)
    else $error("processor clock not stopped within latency");

  a_halt_resume: assert property (
    @(posedge clk) disable iff (!arst_n)
    (proc_if.run_req && s_r.phase == PH_RUN) [*7] |-> proc_if.en)
    else $error("processor clock not restarted within latency");

endmodule : sllg_top

`default_nettype wire

// ### src/sllg_consts.svh
// constants of the strap latch and output gating block
// assumes a 50 MHz core clock and a power-detect reset
`ifndef SLLG_CONSTS_SVH
`define SLLG_CONSTS_SVH

`define SLLG_CLK_MHZ     50
`define SLLG_WIN_TIME_US 2000
`define SLLG_WIN_W       17

`define SLLG_ADDR_CTRL   12'h000
`define SLLG_ADDR_STAT   12'h004
`define SLLG_ADDR_STRAP  12'h008

`define SLLG_CTRL_W      7
`define SLLG_CTRL_RST    7'h00
`define SLLG_CTRL_MHALT  5
`define SLLG_CTRL_PHALT  6
`define SLLG_STRAP_RST   5'h00

`define SLLG_PIN_MODE    0
`define SLLG_PIN_FS3     1
`define SLLG_PIN_FS0     2
`define SLLG_PIN_FS1     3
`define SLLG_PIN_FS2     4

`define SLLG_DIV_W       4
`define SLLG_DIV_PROC    0
`define SLLG_DIV_USB     0
`define SLLG_DIV_SIO     1
`define SLLG_DIV_BUS     2

`endif

// ### src/sllg_pkg.sv
// types of the strap latch and output gating block
// assumes sllg_consts.svh on the include path
`include "sllg_consts.svh"

package sllg_pkg;

  typedef enum logic [1:0]
  {
    PH_RESET  = 2'b00,
    PH_WINDOW = 2'b01,
    PH_LATCH  = 2'b10,
    PH_RUN    = 2'b11
  } sllg_phase_type;

  typedef struct packed
  {
    logic [1:0]              rsync;
    sllg_phase_type          phase;
    logic [`SLLG_WIN_W-1:0]  win_cnt;
    logic [4:0]              strap;
    logic [4:0]              oe;
    logic [4:0]              pout;
    logic                    pin2_o;
    logic                    pin2_oe;
    logic [`SLLG_DIV_W-1:0]  div;
    logic                    bus_samp;
    logic                    bus_run;
    logic [4:0]              bus_out;
    logic                    proc_free;
    logic                    mem_free;
    logic [`SLLG_CTRL_W-1:0] ctrl;
    logic [31:0]             prdata;
    logic                    pslverr;
  } sllg_top_state_type;

  typedef struct packed
  {
    logic [1:0] sync;
    logic       en;
    logic       gated;
  } sllg_gate_state_type;

endpackage : sllg_pkg

// ### src/sllg_gate_if.sv
// carrier between the top and one clock gate
// assumes src and tick are synchronous to the core clock
`timescale 1ns/1ps
`default_nettype none

interface sllg_gate_if;
  logic src;
  logic tick;
  logic run_req;
  logic gated;
  logic en;

  modport ctl
  (
    output src,
    output tick,
    output run_req,
    input  gated,
    input  en
  );

  modport gate
  (
    input  src,
    input  tick,
    input  run_req,
    output gated,
    output en
  );
endinterface : sllg_gate_if

`default_nettype wire

// ### src/sllg_gate.sv
// whole-cycle clock gate with a two-tick run request synchroniser
// assumes tick marks each processor clock rise
`timescale 1ns/1ps
`default_nettype none

module sllg_gate
  import sllg_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // gated source
  sllg_gate_if.gate gi
);

  sllg_gate_state_type s_r;
  sllg_gate_state_type s_nxt;

  // ==========================================================
  // gating
  always_comb
  begin
    s_nxt = s_r;
    if (gi.tick)
    begin
      s_nxt.sync = {s_r.sync[0], gi.run_req};
    end
    // enable moves only while source is low: whole cycles only
    if (!gi.src)
    begin
      s_nxt.en = s_r.sync[1];
    end
    s_nxt.gated = gi.src & s_nxt.en;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_r <= '{sync: 2'h3, en: 1'b1, gated: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign gi.gated = s_r.gated;
  assign gi.en    = s_r.en;

  // ==========================================================
  // checks
  a_gate_stop_low: assert property (
    @(posedge clk) disable iff (!arst_n)
    $fell(s_r.en) |-> !$past(gi.src))
    else $error("gate stopped inside a high phase");

  a_gate_start_low: assert property (
    @(posedge clk) disable iff (!arst_n)
    $rose(s_r.en) |-> !$past(gi.src) && !gi.gated)
    else $error("gate restarted with a partial cycle");

endmodule : sllg_gate

`default_nettype wire

// ### verif/sllg_board.sv
// board side model: strap resistors, bus stop driver, pin wire levels
// assumes enables are high while the block drives a pin
`timescale 1ns/1ps
`default_nettype none

module sllg_board
(
  // board settings
  input  wire logic [4:0] pull,
  input  wire logic       stop_n,
  // dual pins
  input  wire logic [4:0] dual_out,
  input  wire logic [4:0] dual_oe,
  output logic [4:0]      strap_in,
  // pin 2
  input  wire logic       pin2_o,
  input  wire logic       pin2_oe,
  output logic            pin2_in
);
  // ==========================================
  // wire resolution
  // resistor sets the level only while the pin is released
  always_comb
  begin
    for (int i = 0; i < 5; i++)
    begin
      strap_in[i] = dual_oe[i] ? dual_out[i] : pull[i];
    end
    pin2_in = pin2_oe ? pin2_o : stop_n;
  end
endmodule : sllg_board

`default_nettype wire

// ### verif/tb_sllg_top.sv
// testbench of the strap latch and output gating block
// assumes the board model beside it and a short strap window
`timescale 1ns/1ps
`default_nettype none
`include "sllg_consts.svh"

module tb_sllg_top;
  // ==========================================
  // signals
  localparam int WIN = 20;
  logic        clk = 0;
  logic        arst_n = 0;
  logic        psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err;
  logic        ref_clk_in = 0, memory_clock_in = 0, clock_halt_n = 1;
  logic [4:0]  strap_in, dual_out, dual_oe, pull = 5'h00;
  logic        pin2_in, reference_out_zero, pin2_oe, stop_n = 1;
  logic [3:0]  bus_clk_out;
  logic        proc_clk_free, gated_processor_clock, memory_clock_free, mprev = 0, rprev = 0;
  logic [11:0] gated_memory_clocks;
  logic [3:0]  tcnt = 4'h0;
  int          mismatches = 0, n_compared = 0;
  int          hi[7] = '{default: 0};
  int          base[7], dlt[7];

  always #10 clk = ~clk;

  sllg_top #(.WIN_CYCLES(WIN)) i_dut (.clk(clk), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_clk_in(ref_clk_in),
    .memory_clock_in(memory_clock_in), .clock_halt_n(clock_halt_n), .strap_in(strap_in),
    .dual_out(dual_out), .dual_oe(dual_oe), .pin2_in(pin2_in),
    .reference_out_zero(reference_out_zero), .pin2_oe(pin2_oe), .bus_clk_out(bus_clk_out),
    .proc_clk_free(proc_clk_free), .gated_processor_clock(gated_processor_clock),
    .gated_memory_clocks(gated_memory_clocks), .memory_clock_free(memory_clock_free));

  sllg_board i_board (.pull(pull), .stop_n(stop_n), .dual_out(dual_out), .dual_oe(dual_oe),
    .strap_in(strap_in), .pin2_o(reference_out_zero), .pin2_oe(pin2_oe), .pin2_in(pin2_in));

  // ==========================================
  // source clocks and activity counters
  always @(posedge clk)
  begin
    tcnt            <= tcnt + 4'h1;
    ref_clk_in      <= tcnt[1];
    memory_clock_in <= tcnt[0];
    mprev           <= memory_clock_in;
    rprev           <= ref_clk_in;
    hi[0] <= hi[0] + int'(bus_clk_out != 4'h0 || dual_out[1] === 1'b1);
    hi[1] <= hi[1] + int'(gated_memory_clocks != 12'h000);
    hi[2] <= hi[2] + int'(gated_processor_clock === 1'b1);
    hi[3] <= hi[3] + int'(reference_out_zero === 1'b1 && pin2_oe === 1'b1);
    hi[4] <= hi[4] + int'(proc_clk_free === 1'b1);
    hi[5] <= hi[5] + int'(memory_clock_free !== mprev);
    hi[6] <= hi[6] + int'(dual_out[`SLLG_PIN_FS2] !== rprev);
  end

  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do
    begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic span(input int n);
    base = hi;
    repeat (n) @(posedge clk);
    foreach (dlt[i]) dlt[i] = hi[i] - base[i];
  endtask : span

  // ==========================================
  // scenarios
  task automatic t_power(input logic [4:0] p);
    pull <= p;
    arst_n <= 0;
    repeat (5) @(posedge clk);
    arst_n <= 1;
    repeat (WIN) @(posedge clk) chk({pin2_oe, dual_oe}, 6'h00);
    span(20);
    chk(dual_oe, 5'h1f);
    chk(dlt[6], 0);
    apb(0, `SLLG_ADDR_STRAP, 0);
    chk(rd[4:0], p);
    chk(pin2_oe, p[`SLLG_PIN_MODE]);
  endtask : t_power

  task automatic t_regs;
    apb(0, `SLLG_ADDR_CTRL, 0);
    chk(rd, 32'h0);
    chk(err, 1'b0);
    apb(1, `SLLG_ADDR_CTRL, 32'h1f);
    apb(0, `SLLG_ADDR_CTRL, 0);
    chk(rd, 32'h1f);
    span(40);
    chk(dlt[0], 0);
    apb(1, `SLLG_ADDR_CTRL, 32'h40);
    span(20);
    span(32);
    chk(dlt[2], 0);
    chk(dlt[1] > 0, 1);
    apb(1, `SLLG_ADDR_CTRL, 32'h20);
    span(20);
    span(32);
    chk(dlt[1], 0);
    chk(dlt[2] > 0, 1);
    apb(1, `SLLG_ADDR_CTRL, 32'h0);
    apb(1, `SLLG_ADDR_STRAP, 32'h1f);
    pull <= ~pull;
    apb(0, `SLLG_ADDR_STRAP, 0);
    chk(rd[4:0], 5'b10110);
    pull <= ~pull;
    apb(0, 12'h00c, 0);
    chk(err, 1'b1);
    apb(0, `SLLG_ADDR_STAT, 0);
    chk(rd & 32'h0d, 32'h0d);
  endtask : t_regs

  task automatic t_busstop;
    stop_n <= 0;
    span(40);
    span(32);
    chk(dlt[0], 0);
    chk(dlt[3], 0);
    stop_n <= 1;
    span(40);
    span(32);
    chk(dlt[0] > 0, 1);
  endtask : t_busstop

  task automatic t_halt;
    clock_halt_n <= 0;
    span(20);
    span(32);
    chk(dlt[1], 0);
    chk(dlt[2], 0);
    chk(dlt[4] > 0, 1);
    chk(dlt[5], 0);
    clock_halt_n <= 1;
    span(20);
    span(32);
    chk({dlt[1] > 0, dlt[2] > 0}, 2'b11);
  endtask : t_halt

  task automatic t_mode1;
    stop_n <= 0;
    t_power(5'b01001);
    span(32);
    chk({dlt[3] > 0, dlt[0] > 0}, 2'b11);
    stop_n <= 1;
  endtask : t_mode1

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // ==========================================
  // main sequence and watchdog
  initial
  begin
    t_power(5'b10110);
    t_regs;
    t_busstop;
    t_halt;
    t_mode1;
    results;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results;
  end
endmodule : tb_sllg_top

`default_nettype wire
